//--- design/acr_control.sv
// Operation
// - Result is ten bits, input times 1024/reference
// - Bits 7:6 choose reference source
// - Selection writes during conversion apply at completion
// - Four-bit channel code: pins, bandgap, ground
// - Alignment bit changes result view immediately
// - Selection bit 4 reads zero, ignores writes
// - Enable powers converter; clearing aborts conversion
// - Writing start begins single or first conversion
// - First conversion 25 cycles, later ones 13
// - Start reads one while busy; zero ignored
// - Auto trigger starts on selected rising edge
// - Done flag sets on every completion, even if locked result is not updated
// - Interrupt when flag, enable and global enable
// - Flag cleared by vector or writing one
// - Prescaler divides system clock 2 to 128
// - Right aligned: low byte bits 7:0
// - Low byte read locks result until high read
// - Left aligned: high byte bits 9:2
// - Trigger source zero is free running, no event
// - Started conversion begins on next converter tick
`timescale 1ns/100ps
`default_nettype none
module acr_control
  import acr_pkg::*;
(
  input  wire logic                   clk,               // System clock
  input  wire logic                   rst_n,             // Async reset
  input  wire logic                   clk_en,            // Freezes all state
  input  wire logic [acr_pkg::ADDR_W-1:0] reg_addr,      // Register address
  input  wire logic [acr_pkg::DATA_W-1:0] reg_wdata,     // Write data
  input  wire logic                   reg_wr,            // Write strobe
  input  wire logic                   reg_rd,            // Read strobe
  output logic      [acr_pkg::DATA_W-1:0] reg_rdata,     // Read data
  input  wire logic                   global_irq_enable, // CPU global enable
  input  wire logic                   irq_vector_taken,  // Vector taken pulse
  input  wire logic [7:1]             trigger_in,        // Trigger flags
  output logic                        irq,               // Completion request
  output logic                        core_power,        // Core powered up
  output logic                        core_start,        // Sample pulse
  output logic                        core_init,         // First conversion
  output logic      [3:0]             core_channel,      // Latched channel
  output logic      [1:0]             core_reference,    // Latched reference
  input  wire logic                   core_done,         // Core result ready
  input  wire logic [9:0]             core_result        // Core result code
);
  import acr_pkg::*;

  // Software view of the selection register
  logic [1:0]  reference_select;     // Reference field
  logic        left_align;           // Alignment bit
  logic [3:0]  channel_select;       // Channel field
  // Control and status fields
  logic        converter_enable;     // Enable bit
  logic        start_req;            // Start requested, waiting for tick
  logic        auto_trigger_enable;  // Auto trigger bit
  logic        conversion_done_flag; // Completion flag
  logic        conversion_irq_enable;// Interrupt enable bit
  logic [2:0]  clock_prescale_select;// Prescaler code
  logic [2:0]  trigger_source_select;// Trigger source code
  // Sequencer
  acr_state_t  state;                // Current state
  logic [4:0]  tick_cnt;             // Converter cycles elapsed
  logic        init_needed;          // Next conversion is the first
  logic [PS_W-1:0] ps_cnt;           // Prescaler counter
  logic        result_lock;          // Low byte read, high pending
  logic [9:0]  result_bits;          // Stored result
  logic        trig_prev;            // Selected trigger, last cycle

  // Decoded strobes
  logic wr_sel, wr_csa, wr_csb, rd_lo, rd_hi;
  assign wr_sel = reg_wr && (reg_addr == OFS_SEL);
  assign wr_csa = reg_wr && (reg_addr == OFS_CSA);
  assign wr_csb = reg_wr && (reg_addr == OFS_CSB);
  assign rd_lo  = reg_rd && (reg_addr == OFS_RLO);
  assign rd_hi  = reg_rd && (reg_addr == OFS_RHI);

  // Converter clock tick from the prescaler
  logic [PS_W-1:0] ps_mask;
  logic            tick;
  always_comb begin
    case (clock_prescale_select)
      3'h0, 3'h1: ps_mask = 7'h01;
      3'h2:       ps_mask = 7'h03;
      3'h3:       ps_mask = 7'h07;
      3'h4:       ps_mask = 7'h0f;
      3'h5:       ps_mask = 7'h1f;
      3'h6:       ps_mask = 7'h3f;
      default:    ps_mask = 7'h7f;
    endcase
  end
  assign tick = converter_enable && ((ps_cnt & ps_mask) == ps_mask);

  // Conversion length and completion
  logic [4:0] conv_len;
  logic       conv_last;
  logic       complete;
  logic       begin_conv;
  assign conv_len   = init_needed ? LEN_FIRST : LEN_NORMAL;
  assign conv_last  = (state == ACR_CONV) && tick
                      && (tick_cnt == conv_len - 5'd1);
  assign complete   = (state == ACR_FINISH) && core_done;
  assign begin_conv = (state == ACR_IDLE) && start_req && tick;
  // Selected trigger and its rising edge
  logic trig_sel;
  logic trig_edge;
  assign trig_sel  = (trigger_source_select == TS_FREE_RUN)
                     ? 1'b0 : trigger_in[trigger_source_select];
  assign trig_edge = auto_trigger_enable && converter_enable
                     && trig_sel && !trig_prev;
  // Free running restarts on each completion
  logic free_restart;
  assign free_restart = complete && auto_trigger_enable
                        && (trigger_source_select == TS_FREE_RUN);

  // Software view of the selection register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_select <= 2'h0;
      left_align       <= 1'b0;
      channel_select   <= 4'h0;
    end else if (clk_en && wr_sel) begin
      // Bit 4 is not stored
      reference_select <= reg_wdata[SEL_REF_HI:SEL_REF_LO];
      left_align       <= reg_wdata[SEL_ALIGN];
      channel_select   <= reg_wdata[SEL_CH_HI:0];
    end
  end
  // Live selection follows software only while idle or finishing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_channel   <= 4'h0;
      core_reference <= 2'h0;
    end else if (clk_en && state != ACR_CONV) begin
      core_channel   <= channel_select;
      core_reference <= reference_select;
    end
  end
  // Control fields of status register A and register B
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_enable      <= 1'b0;
      auto_trigger_enable   <= 1'b0;
      conversion_irq_enable <= 1'b0;
      clock_prescale_select <= 3'h0;
      trigger_source_select <= 3'h0;
    end else if (clk_en) begin
      if (wr_csa) begin
        converter_enable      <= reg_wdata[CSA_EN];
        auto_trigger_enable   <= reg_wdata[CSA_AUTO];
        conversion_irq_enable <= reg_wdata[CSA_IE];
        clock_prescale_select <= reg_wdata[CSA_PS_HI:0];
      end
      if (wr_csb) begin
        trigger_source_select <= reg_wdata[CSB_TS_HI:0];
      end
    end
  end
  // Start request: set by software or trigger, cleared on begin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_req <= 1'b0;
    end else if (clk_en) begin
      if (wr_csa && !reg_wdata[CSA_EN]) begin
        start_req <= 1'b0;
      end else if (begin_conv) begin
        start_req <= 1'b0;
      end else if (state == ACR_IDLE && !start_req) begin
        if (wr_csa && reg_wdata[CSA_START]) begin
          start_req <= 1'b1;
        end else if (trig_edge) begin
          start_req <= 1'b1;
        end
      end else if (free_restart && converter_enable) begin
        start_req <= 1'b1;
      end
    end
  end
  // First-conversion marker, rearmed whenever the converter is off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_needed <= 1'b1;
    end else if (clk_en) begin
      if (!converter_enable || (wr_csa && !reg_wdata[CSA_EN])) begin
        init_needed <= 1'b1;
      end else if (complete) begin
        init_needed <= 1'b0;
      end
    end
  end
  // Prescaler counter runs only while enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_cnt <= '0;
    end else if (clk_en) begin
      if (!converter_enable) begin
        ps_cnt <= '0;
      end else begin
        ps_cnt <= ps_cnt + 7'd1;
      end
    end
  end
  // Conversion sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ACR_IDLE;
      tick_cnt <= 5'd0;
    end else if (clk_en) begin
      if (wr_csa && !reg_wdata[CSA_EN]) begin
        state    <= ACR_IDLE;
        tick_cnt <= 5'd0;
      end else begin
        case (state)
          ACR_IDLE: begin
            tick_cnt <= 5'd0;
            if (begin_conv) begin
              state <= ACR_CONV;
            end
          end
          ACR_CONV: begin
            if (conv_last) begin
              state <= ACR_FINISH;
            end else if (tick) begin
              tick_cnt <= tick_cnt + 5'd1;
            end
          end
          ACR_FINISH: begin
            if (core_done) begin
              state <= ACR_IDLE;
            end
          end
          default: begin
            state <= ACR_IDLE;
          end
        endcase
      end
    end
  end
  // Core control outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_power <= 1'b0;
      core_start <= 1'b0;
      core_init  <= 1'b0;
    end else if (clk_en) begin
      core_power <= converter_enable;
      core_start <= begin_conv;
      if (begin_conv) begin
        core_init <= init_needed;
      end
    end
  end

  // Result capture, held off while the low byte is locked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_bits <= RST_RESULT;
    end else if (clk_en && complete && !result_lock) begin
      result_bits <= core_result;
    end
  end

  // Result lock between low and high byte reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_lock <= 1'b0;
    end else if (clk_en) begin
      if (rd_hi) begin
        result_lock <= 1'b0;
      end else if (rd_lo) begin
        result_lock <= 1'b1;
      end
    end
  end

  // Completion flag: a completion wins over any clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_flag <= 1'b0;
    end else if (clk_en) begin
      if (complete) begin
        conversion_done_flag <= 1'b1;
      end else if (irq_vector_taken
                   || (wr_csa && reg_wdata[CSA_FLAG])) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  // Trigger edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev <= 1'b0;
    end else if (clk_en) begin
      trig_prev <= trig_sel;
    end
  end

  // Interrupt request output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= conversion_done_flag && conversion_irq_enable
             && global_irq_enable;
    end
  end

  // Result presentation follows the alignment bit at once
  logic [7:0] res_lo;
  logic [7:0] res_hi;
  always_comb begin
    if (left_align) begin
      res_hi = result_bits[9:2];
      res_lo = {result_bits[1:0], 6'h00};
    end else begin
      res_hi = {6'h00, result_bits[9:8]};
      res_lo = result_bits[7:0];
    end
  end

  // Read data mux
  logic       busy;
  logic [7:0] rd_mux;
  assign busy = start_req || (state != ACR_IDLE);
  always_comb begin
    case (reg_addr)
      OFS_SEL: rd_mux = {reference_select, left_align, 1'b0,
                         channel_select};
      OFS_CSA: rd_mux = {converter_enable, busy, auto_trigger_enable,
                         conversion_done_flag, conversion_irq_enable,
                         clock_prescale_select};
      OFS_CSB: rd_mux = {5'h00, trigger_source_select};
      OFS_RLO: rd_mux = res_lo;
      OFS_RHI: rd_mux = res_hi;
      default: rd_mux = RST_BYTE;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_BYTE;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : RST_BYTE;
    end
  end

  // Checks on the sequencer and register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_read_ctrl;
    clk_en && reg_rd && reg_addr == OFS_CSA;
  endsequence
  sequence seq_read_high;
    clk_en && reg_rd && reg_addr == OFS_RHI;
  endsequence
  sequence seq_read_low;
    clk_en && reg_rd && reg_addr == OFS_RLO;
  endsequence

  flag_set_a: assert property (
    clk_en && complete |=> conversion_done_flag)
    else $error("done flag not set on completion");
  irq_out_a: assert property (
    clk_en && conversion_done_flag && conversion_irq_enable
    && global_irq_enable |=> irq)
    else $error("interrupt not raised");
  flag_clear_a: assert property (
    clk_en && wr_csa && reg_wdata[CSA_FLAG] && !complete
    |=> !conversion_done_flag)
    else $error("done flag not cleared by write one");
  sel_hold_a: assert property (
    clk_en && state == ACR_CONV && wr_sel |=> $stable(core_channel))
    else $error("channel changed during conversion");
  abort_conv_a: assert property (
    clk_en && wr_csa && !reg_wdata[CSA_EN]
    |=> state == ACR_IDLE && !start_req)
    else $error("disable did not abort conversion");
  busy_read_a: assert property (
    seq_read_ctrl ##0 busy |=> reg_rdata[CSA_START])
    else $error("start bit not read as one while busy");
  left_view_a: assert property (
    seq_read_high ##0 left_align |=> reg_rdata == $past(result_bits[9:2]))
    else $error("left aligned high byte wrong");
  right_view_a: assert property (
    seq_read_low ##0 !left_align |=> reg_rdata == $past(result_bits[7:0]))
    else $error("right aligned low byte wrong");
  bit_four_a: assert property (
    clk_en && reg_rd && reg_addr == OFS_SEL |=> !reg_rdata[4])
    else $error("unused selection bit reads one");
  tick_begin_a: assert property (
    begin_conv && clk_en |=> state == ACR_CONV ##0 core_start)
    else $error("conversion did not begin on tick");
  lock_hold_a: assert property (
    clk_en && result_lock && !rd_hi |=> $stable(result_bits))
    else $error("result changed while locked");
endmodule : acr_control
`default_nettype wire

//--- inc/acr_pkg.sv
// Shared constants for the converter control and result block
package acr_pkg;
  // Register bus geometry
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned DATA_W   = 8;
  // Register offsets (one byte register per address)
  localparam logic [2:0] OFS_SEL   = 3'h0;  // channel_reference_select
  localparam logic [2:0] OFS_CSA   = 3'h1;  // converter_control_status_a
  localparam logic [2:0] OFS_CSB   = 3'h2;  // converter_control_status_b
  localparam logic [2:0] OFS_RLO   = 3'h3;  // result_low_byte
  localparam logic [2:0] OFS_RHI   = 3'h4;  // result_high_byte
  // Field positions in channel_reference_select
  localparam int unsigned SEL_REF_HI = 7;
  localparam int unsigned SEL_REF_LO = 6;
  localparam int unsigned SEL_ALIGN  = 5;
  localparam int unsigned SEL_CH_HI  = 3;
  // Field positions in converter_control_status_a
  localparam int unsigned CSA_EN     = 7;
  localparam int unsigned CSA_START  = 6;
  localparam int unsigned CSA_AUTO   = 5;
  localparam int unsigned CSA_FLAG   = 4;
  localparam int unsigned CSA_IE     = 3;
  localparam int unsigned CSA_PS_HI  = 2;
  // Field positions in converter_control_status_b
  localparam int unsigned CSB_TS_HI  = 2;
  // Reset values
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [9:0] RST_RESULT  = 10'h000;
  // Reference codes
  localparam logic [1:0] REF_EXT_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY  = 2'h1;
  localparam logic [1:0] REF_RSVD    = 2'h2;
  localparam logic [1:0] REF_INT_1V1 = 2'h3;
  // Last of the eight input codes, and channel codes beyond them
  localparam logic [3:0] CH_LAST_PIN = 4'h7;
  localparam logic [3:0] CH_BANDGAP  = 4'he;
  localparam logic [3:0] CH_GROUND   = 4'hf;
  // Trigger source code for free running
  localparam logic [2:0] TS_FREE_RUN = 3'h0;
  // Conversion lengths in converter clock cycles
  localparam logic [4:0] LEN_FIRST   = 5'd25;
  localparam logic [4:0] LEN_NORMAL  = 5'd13;
  // Prescaler counter width (largest divide is 128)
  localparam int unsigned PS_W       = 7;
  // Conversion sequencer states, Gray coded along idle-convert-finish
  typedef enum logic [1:0] {
    ACR_IDLE   = 2'b00,
    ACR_CONV   = 2'b01,
    ACR_FINISH = 2'b11
  } acr_state_t;
endpackage : acr_pkg

//--- tb/acr_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module acr_core_model (
  input  wire logic       clk,            // System clock
  input  wire logic       rst_n,          // Async reset
  input  wire logic       core_start,     // Sample pulse
  input  wire logic [3:0] core_channel,   // Selected input
  input  wire logic [1:0] core_reference, // Selected reference
  output logic            core_done,      // Result ready
  output logic      [9:0] core_result     // Result code
);
  logic [9:0] code; // Code of the sampled input
  // Code is fixed at sampling time, so a late selection change cannot leak
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_done <= 1'b0;
      code      <= 10'h000;
    end else if (core_start) begin
      core_done <= 1'b1;
      code      <= {core_reference, core_channel, 4'ha};
    end
  end
  // Lines show a wrong code while nothing is ready
  assign core_result = core_done ? code : ~code;
endmodule : acr_core_model
`default_nettype wire

//--- tb/adc_control_result_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_control_result_regs_tb;
  import acr_pkg::*;
  logic       clk = 1'b0;        // System clock
  logic       rst_n = 1'b0;      // Reset, active low
  logic       ce = 1'b1;         // Clock enable
  logic [2:0] reg_addr = 3'h0;   // Register address
  logic [7:0] reg_wdata = 8'h00; // Write data
  logic       reg_wr = 1'b0;     // Write strobe
  logic       reg_rd = 1'b0;     // Read strobe
  logic       gie = 1'b0;        // Global interrupt enable
  logic       vec = 1'b0;        // Vector taken pulse
  logic [7:1] trig = 7'h00;      // Trigger flags
  logic [7:0] reg_rdata;         // Read data
  logic       irq;               // Completion request
  logic       core_power;        // Core powered
  logic       core_start;        // Core sample pulse
  logic       core_init;         // First conversion marker
  logic       core_done;         // Core result ready
  logic [3:0] core_channel;      // Latched channel
  logic [1:0] core_reference;    // Latched reference
  logic [9:0] core_result;       // Core code
  int         err_count = 0;     // Mismatches
  int         checks = 0;        // Comparisons
  int         cyc = 0;           // Watchdog count
  int         starts = 0;        // Conversion starts seen
  int         n, n0, n1;         // Start to request cycles
  always #10 clk = ~clk;
  acr_control u_acr_control (.clk(clk), .rst_n(rst_n), .clk_en(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_enable(gie),
    .irq_vector_taken(vec), .trigger_in(trig), .irq(irq),
    .core_power(core_power), .core_start(core_start),
    .core_init(core_init),
    .core_channel(core_channel), .core_reference(core_reference),
    .core_done(core_done), .core_result(core_result));
  acr_core_model u_acr_core_model (.clk(clk), .rst_n(rst_n),
    .core_start(core_start), .core_channel(core_channel),
    .core_reference(core_reference), .core_done(core_done),
    .core_result(core_result));
  // Count starts and cut a hang short
  always @(posedge clk) begin
    if (core_start === 1'b1)
      starts++;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %0d", a), e, reg_rdata);
  endtask : rdchk
  task automatic wait_start(input int s);
    int k;
    k = 0;
    while (starts == s && k < 400) begin
      @(posedge clk);
      #1 k++;
    end
  endtask : wait_start
  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_irq
  // One conversion, timed from core start to request, then flag cleared
  task automatic run_conv(input logic [7:0] csa);
    int s;
    s = starts;
    wr(OFS_CSA, csa);
    wait_start(s);
    wait_irq;
    wr(OFS_CSA, (csa & 8'hbf) | 8'h10);
    @(posedge clk);
    #1 chk("irq", 8'h00, {7'h0, irq});
  endtask : run_conv
  task automatic t_reset;
    for (int a = 0; a < 6; a++)
      rdchk(3'(a), 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_route;
    logic [7:0] v;
    wr(OFS_SEL, 8'hff);
    rdchk(OFS_SEL, 8'hef);
    // A write while the clock enable is low must not land
    @(posedge clk) ce <= 1'b0;
    wr(OFS_SEL, 8'h00);
    @(posedge clk) ce <= 1'b1;
    rdchk(OFS_SEL, 8'hef);
    for (int k = 0; k < 16; k++) begin
      v = {k[1:0], 2'h0, k[3:0]};
      wr(OFS_SEL, v);
      repeat (2) @(posedge clk);
      #1 chk("route", v, {core_reference, 2'h0, core_channel});
    end
    $display("test route done");
  endtask : t_route
  task automatic t_first;
    @(posedge clk) gie <= 1'b1;
    wr(OFS_SEL, 8'h43);
    run_conv(8'hc8);
    n1 = n;
    chk("init", 8'h01, {7'h0, core_init});
    run_conv(8'hc8);
    chk("init", 8'h00, {7'h0, core_init});
    chk("first", 8'h18, 8'(n1 - n));
    rdchk(OFS_RLO, 8'h3a);
    rdchk(OFS_RHI, 8'h01);
    wr(OFS_SEL, 8'h63);
    rdchk(OFS_RLO, 8'h80);
    rdchk(OFS_RHI, 8'h4e);
    $display("test first done");
  endtask : t_first
  task automatic t_scale;
    int d;
    for (int k = 0; k < 8; k++) begin
      run_conv(8'hc8 | 8'(k));
      if (k == 0)
        n0 = n;
      d = (k < 2) ? 2 : (1 << k);
      chk("scale", 8'h00, 8'(n - n0 - 13 * (d - 2)));
    end
    $display("test scale done");
  endtask : t_scale
  task automatic t_busy;
    int s;
    wr(OFS_SEL, 8'h43);
    s = starts;
    wr(OFS_CSA, 8'hc8);
    wait_start(s);
    rdchk(OFS_CSA, 8'hc8);
    wr(OFS_CSA, 8'h88);
    rdchk(OFS_CSA, 8'hc8);
    wr(OFS_SEL, 8'h05);
    chk("chan", 8'h43, {core_reference, 2'h0, core_channel});
    wait_irq;
    rdchk(OFS_RLO, 8'h3a);
    rdchk(OFS_RHI, 8'h01);
    rdchk(OFS_CSA, 8'h98);
    wr(OFS_CSA, 8'h88);
    rdchk(OFS_CSA, 8'h98);
    wr(OFS_CSA, 8'h98);
    rdchk(OFS_CSA, 8'h88);
    $display("test busy done");
  endtask : t_busy
  task automatic t_lock;
    run_conv(8'hc8);
    rdchk(OFS_RLO, 8'h5a);
    wr(OFS_SEL, 8'h47);
    run_conv(8'hc8);
    rdchk(OFS_RHI, 8'h00);
    rdchk(OFS_RLO, 8'h5a);
    rdchk(OFS_RHI, 8'h00);
    run_conv(8'hc8);
    rdchk(OFS_RLO, 8'h7a);
    rdchk(OFS_RHI, 8'h01);
    $display("test lock done");
  endtask : t_lock
  task automatic t_irq;
    int s;
    @(posedge clk) gie <= 1'b0;
    s = starts;
    wr(OFS_CSA, 8'hc8);
    wait_start(s);
    repeat (60) @(posedge clk);
    #1 chk("irq", 8'h00, {7'h0, irq});
    rdchk(OFS_CSA, 8'h98);
    @(posedge clk) gie <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("irq", 8'h01, {7'h0, irq});
    @(posedge clk) vec <= 1'b1;
    @(posedge clk) vec <= 1'b0;
    rdchk(OFS_CSA, 8'h88);
    chk("irq", 8'h00, {7'h0, irq});
    $display("test irq done");
  endtask : t_irq
  task automatic t_abort;
    int s;
    s = starts;
    wr(OFS_CSA, 8'hc8);
    wait_start(s);
    wr(OFS_CSA, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk("power", 8'h00, {7'h0, core_power});
    repeat (60) @(posedge clk);
    rdchk(OFS_CSA, 8'h08);
    run_conv(8'hc8);
    chk("rearm", 8'h00, 8'(n - n1));
    $display("test abort done");
  endtask : t_abort
  task automatic t_auto;
    int s;
    wr(OFS_CSB, 8'h02);
    s = starts;
    wr(OFS_CSA, 8'ha8);
    @(posedge clk) trig[2] <= 1'b1;
    wait_start(s);
    chk("auto", 8'h01, 8'(starts - s));
    wait_irq;
    s = starts;
    wr(OFS_CSB, 8'h00);
    @(posedge clk) trig[2] <= 1'b0;
    repeat (60) @(posedge clk);
    #1 chk("switch", 8'h00, 8'(starts - s));
    wr(OFS_CSA, 8'hf8);
    repeat (120) @(posedge clk);
    #1 chk("free", 8'h01, {7'h0, (starts - s) >= 3});
    wr(OFS_CSA, 8'h10);
    $display("test auto done");
  endtask : t_auto
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_route;
    t_first;
    t_scale;
    t_busy;
    t_lock;
    t_irq;
    t_abort;
    t_auto;
    close_out;
  end
endmodule : adc_control_result_regs_tb
`default_nettype wire
